// *** verilog/afc_pkg.sv ***
// Purpose: constants, types and helpers for the automatic flow control block
// Assumes: 40 MHz sys_clk, register port with one-cycle read latency
// Notes: thresholds count 64-byte units of receive FIFO fill
package afc_pkg;

	// Register map
	localparam logic [7:0] CFG_OFFSET = 8'hAC;
	localparam logic [7:0] STATUS_OFFSET = 8'hB4;
	localparam logic [23:0] CFG_RESET = 24'h000000;

	// Field positions in flow_control_config
	localparam int HI_LSB = 16;
	localparam int LO_LSB = 8;
	localparam int DUR_LSB = 4;
	localparam int SEL_MULTICAST = 3;
	localparam int SEL_BROADCAST = 2;
	localparam int SEL_OWN_ADDR = 1;
	localparam int SEL_ANY = 0;

	// One threshold unit is 64 bytes
	localparam int LVL_UNIT_SHIFT = 6;

	// Clock and jam duration timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int DUR_STEP_SHORT_NS = 5000;
	localparam int DUR_CODE3_NS = 25000;
	localparam int DUR_STEP_LONG_NS = 50000;
	localparam int DUR_10M_EXTRA_NS = 2200;

	typedef enum logic [1:0] {
		PS_IDLE,
		PS_REQ_PAUSE,
		PS_PAUSED,
		PS_REQ_ZERO
	} afc_pause_state_t;

	// Jam duration in ns for a code and link speed
	function automatic int afc_dur_ns(input logic [3:0] code, input logic is_10m);
		int t;
		if (code < 4'h3) begin
			t = DUR_STEP_SHORT_NS * (int'(code) + 1);
		end else if (code == 4'h3) begin
			t = DUR_CODE3_NS;
		end else begin
			t = DUR_STEP_LONG_NS * (int'(code) - 3);
		end
		if (is_10m) begin
			t = t + DUR_10M_EXTRA_NS;
		end
		return t;
	endfunction

	// Cycle count, rounded up, never below one
	function automatic int afc_dur_cycles(input logic [3:0] code, input logic is_10m,
		input int clk_ns);
		int c;
		c = (afc_dur_ns(code, is_10m) + clk_ns - 1) / clk_ns;
		if (c < 1) begin
			c = 1;
		end
		return c;
	endfunction

endpackage

// *** verilog/afc_jam_timer.sv ***
// Purpose: counts the back pressure duration in sys_clk cycles
// Assumes: start is a one-cycle pulse; a new start reloads the count
// Notes: busy covers cycles 1..N-1 after start, the caller covers cycle 0
`timescale 1ns/1ps
module afc_jam_timer
	import afc_pkg::*;
#(
	parameter int CLK_NS = CLK_PERIOD_NS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Control
	input wire logic start,
	input wire logic [3:0] code,
	input wire logic speed_10,
	// Status
	output logic busy
);

	typedef struct packed {
		logic [15:0] cnt;
		logic busy;
	} afc_timer_st_t;

	afc_timer_st_t st;
	afc_timer_st_t next_st;
	logic [15:0] load;

	// Terminal count follows code and current speed
	assign load = 16'(afc_dur_cycles(code, speed_10, CLK_NS) - 1);

	// Reload on start so back-to-back frames stretch the jam
	always_comb begin
		next_st = st;
		if (start) begin
			next_st.cnt = load;
		end else if (st.cnt != 16'h0000) begin
			next_st.cnt = st.cnt - 16'h0001;
		end
		next_st.busy = (next_st.cnt != 16'h0000);
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign busy = st.busy;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_timer_load: assert property (start |=> st.cnt == $past(load))
		else $error("jam timer did not load its terminal count");

	a_timer_count: assert property (
		!start && st.cnt != 16'h0000 |=> st.cnt == $past(st.cnt) - 16'h0001)
		else $error("jam timer skipped a count");

endmodule // afc_jam_timer

// *** verilog/afc_flow_ctrl.sv ***
// Purpose: automatic pause frame and back pressure control from RX FIFO fill
// Assumes: MAC status inputs and frame event pulses synchronous to sys_clk
// Notes: pause_req holds until pause_ack or until tx_enabled falls; jam is a level towards the MAC
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module afc_flow_ctrl
	import afc_pkg::*;
#(
	parameter int FILL_W = 16,
	parameter int CLK_NS = CLK_PERIOD_NS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// MAC status
	input wire logic tx_enabled,
	input wire logic full_duplex,
	input wire logic speed_10,
	// Receive side
	input wire logic [FILL_W-1:0] rx_fifo_used,
	input wire logic rx_preamble,
	input wire logic rx_da_valid,
	input wire logic rx_da_multicast,
	input wire logic rx_da_broadcast,
	input wire logic rx_da_own,
	// Pause request to MAC
	output logic pause_req,
	output logic pause_zero,
	input wire logic pause_ack,
	// Back pressure to MAC
	output logic jam
);

	typedef struct packed {
		logic [23:0] cfg;
		logic [31:0] rdata;
		afc_pause_state_t ps;
		logic pause_req;
		logic pause_zero;
		logic jam;
	} afc_st_t;

	afc_st_t st;
	afc_st_t next_st;

	logic [7:0] fifo_high_threshold;
	logic [7:0] fifo_low_threshold;
	logic [3:0] jam_duration_code;
	logic jam_on_multicast;
	logic jam_on_broadcast;
	logic jam_on_own_address;
	logic flow_on_any_frame;
	logic [FILL_W-1:0] thr_hi;
	logic [FILL_W-1:0] thr_lo;
	logic hi_reached;
	logic below_lo;
	logic fd_active;
	logic hd_active;
	logic frame_match;
	logic jam_trigger;
	logic timer_busy;

	// Config fields
	assign fifo_high_threshold = st.cfg[HI_LSB +: 8];
	assign fifo_low_threshold = st.cfg[LO_LSB +: 8];
	assign jam_duration_code = st.cfg[DUR_LSB +: 4];
	assign jam_on_multicast = st.cfg[SEL_MULTICAST];
	assign jam_on_broadcast = st.cfg[SEL_BROADCAST];
	assign jam_on_own_address = st.cfg[SEL_OWN_ADDR];
	assign flow_on_any_frame = st.cfg[SEL_ANY];

	// Thresholds scaled to bytes
	assign thr_hi = FILL_W'(fifo_high_threshold) << LVL_UNIT_SHIFT;
	assign thr_lo = FILL_W'(fifo_low_threshold) << LVL_UNIT_SHIFT;
	assign hi_reached = (rx_fifo_used >= thr_hi);
	assign below_lo = (rx_fifo_used < thr_lo);

	// Flow control only runs with the transmitter on
	assign fd_active = tx_enabled && full_duplex && flow_on_any_frame;
	assign hd_active = tx_enabled && !full_duplex;

	// Any-frame skips address decode and fires on preamble
	always_comb begin
		if (flow_on_any_frame) begin
			frame_match = rx_preamble;
		end else begin
			frame_match = rx_da_valid && ((jam_on_multicast && rx_da_multicast)
				|| (jam_on_broadcast && rx_da_broadcast)
				|| (jam_on_own_address && rx_da_own));
		end
	end

	assign jam_trigger = hd_active && hi_reached && frame_match;

	afc_jam_timer #(
		.CLK_NS(CLK_NS)
	) u_timer (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.start(jam_trigger),
		.code(jam_duration_code),
		.speed_10(speed_10),
		.busy(timer_busy)
	);

	// Register access, pause sequencing and jam output
	always_comb begin
		next_st = st;
		next_st.rdata = 32'h00000000;
		if (reg_wr && reg_addr == CFG_OFFSET) begin
			next_st.cfg = reg_wdata[23:0];
		end
		if (reg_rd) begin
			unique case (reg_addr)
				CFG_OFFSET: next_st.rdata = {8'h00, st.cfg};
				STATUS_OFFSET: next_st.rdata = {26'h0, st.jam, st.pause_req,
					(st.ps == PS_PAUSED), hi_reached, below_lo, timer_busy};
				default: next_st.rdata = 32'h00000000;
			endcase
		end
		// One pause per high crossing, zero pause only after it
		unique case (st.ps)
			PS_IDLE: begin
				if (fd_active && hi_reached) begin
					next_st.ps = PS_REQ_PAUSE;
				end
			end
			PS_REQ_PAUSE: begin
				if (!tx_enabled) begin
					next_st.ps = PS_IDLE;
				end else if (pause_ack) begin
					next_st.ps = PS_PAUSED;
				end
			end
			PS_PAUSED: begin
				if (tx_enabled && below_lo) begin
					next_st.ps = PS_REQ_ZERO;
				end
			end
			PS_REQ_ZERO: begin
				if (!tx_enabled) begin
					next_st.ps = PS_PAUSED;
				end else if (pause_ack) begin
					next_st.ps = PS_IDLE;
				end
			end
		endcase
		next_st.pause_req = (next_st.ps == PS_REQ_PAUSE) || (next_st.ps == PS_REQ_ZERO);
		next_st.pause_zero = (next_st.ps == PS_REQ_ZERO);
		// Jam cycle 0 from the trigger, then the timer; jam held low in full duplex
		next_st.jam = hd_active && (jam_trigger || timer_busy);
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			st <= '0;
			st.cfg <= CFG_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign pause_req = st.pause_req;
	assign pause_zero = st.pause_zero;
	assign jam = st.jam;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_txoff_quiet: assert property (!tx_enabled |=> !pause_req && !jam)
		else $error("flow control active with transmitter disabled");

	a_hi_pause_req: assert property (
		st.ps == PS_IDLE && fd_active && hi_reached |=> pause_req && !pause_zero)
		else $error("high threshold did not request a pause frame");

	// A fast drain may legally ask for the zero pause right after the quiet cycle
	a_single_pause: assert property (
		pause_req && !pause_zero && pause_ack && tx_enabled
		|=> !pause_req ##1 (!pause_req || pause_zero))
		else $error("second pause frame requested for one crossing");

	a_hd_jam_start: assert property (jam_trigger |=> jam)
		else $error("matching frame was not jammed");

	a_zero_pause: assert property (
		st.ps == PS_PAUSED && tx_enabled && below_lo |=> pause_req && pause_zero)
		else $error("low threshold did not request a zero pause");

	a_zero_after_pause: assert property (
		$rose(pause_zero) |-> $past(st.ps) == PS_PAUSED)
		else $error("zero pause without an earlier pause frame");

	a_fd_no_jam: assert property (full_duplex |=> !jam)
		else $error("back pressure in full duplex");

	a_any_only_fd: assert property (
		!flow_on_any_frame && st.ps == PS_IDLE |=> !pause_req)
		else $error("full duplex pause without any-frame select");

	a_any_overrides: assert property (
		flow_on_any_frame && hd_active && hi_reached && !rx_preamble && !jam && !timer_busy
		|=> !jam)
		else $error("selection bits acted while any-frame set");

	a_mcast_jam: assert property (
		hd_active && hi_reached && !flow_on_any_frame && jam_on_multicast
		&& rx_da_valid && rx_da_multicast |=> jam ##1 (jam || !hd_active))
		else $error("multicast frame not jammed");

	a_bcast_jam: assert property (
		hd_active && hi_reached && !flow_on_any_frame && jam_on_broadcast
		&& rx_da_valid && rx_da_broadcast |=> jam)
		else $error("broadcast frame not jammed");

	a_own_jam: assert property (
		hd_active && hi_reached && !flow_on_any_frame && jam_on_own_address
		&& rx_da_valid && rx_da_own |=> jam)
		else $error("frame for this station not jammed");

	a_any_preamble: assert property (
		hd_active && hi_reached && flow_on_any_frame && rx_preamble |=> jam)
		else $error("preamble did not start back pressure");

	// The MAC may sit on the request until its next transmit window
	a_pause_holds: assert property (
		pause_req && !pause_ack && tx_enabled |=> pause_req)
		else $error("pause request dropped before the MAC took it");

	a_jam_ends: assert property (
		jam && !timer_busy && !jam_trigger |=> !jam)
		else $error("back pressure outlived its duration");

	c_fd_cycle: cover property (pause_req && !pause_zero ##[1:300] pause_req && pause_zero);
	c_hd_jam: cover property (jam_trigger ##1 jam [*8]);
	c_txoff_abort: cover property (st.ps == PS_REQ_PAUSE && !tx_enabled);
	c_any_jam: cover property (flow_on_any_frame && jam_trigger);
	c_class_jam: cover property (!flow_on_any_frame && jam_trigger);

endmodule // afc_flow_ctrl

// *** verification/afc_mac_model.sv ***
// Purpose: MAC side that accepts pause requests
// Assumes: pause_req holds until pause_ack unless withdrawn
// Notes: delay picks prompt or slow acceptance
`timescale 1ns/1ps
module afc_mac_model (
	// Clock
	input wire logic sys_clk,
	// Pause link
	input wire logic pause_req,
	input wire logic [7:0] delay,
	output logic pause_ack = 1'b0
);
	int wait_cnt = 0;
	// One-cycle ack after delay edges; a queued frame is not instant
	always @(posedge sys_clk) begin
		pause_ack <= 1'b0;
		if (pause_req && !pause_ack) begin
			if (wait_cnt >= delay) begin
				pause_ack <= 1'b1;
				wait_cnt <= 0;
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end else if (!pause_req) begin
			wait_cnt <= 0; // Withdrawn request starts the wait afresh
		end
	end
endmodule // afc_mac_model

// *** verification/test_auto_flow_control.sv ***
// Purpose: self-checking bench for auto flow control
// Assumes: CLK_NS scaled to 2500 so jam counts stay short
// Notes: inputs change 1 ns after each rising edge
`timescale 1ns/1ps
module test_auto_flow_control;
	localparam int TB_NS = 2500;
	logic sys_clk, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic tx_enabled = 1'b0, full_duplex = 1'b1, speed_10 = 1'b0;
	logic [7:0] reg_addr = 8'h00, ack_delay = 8'h0A;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val, cfg;
	logic [15:0] rx_fifo_used = 16'h0;
	logic rx_preamble = 1'b0, rx_da_valid = 1'b0, rx_da_multicast = 1'b0;
	logic rx_da_broadcast = 1'b0, rx_da_own = 1'b0;
	logic pause_req, pause_zero, pause_ack, jam;
	int fail_count = 0;
	int checks_done = 0;
	int len;
	integer seed = 32'hE8611AC5;

	afc_flow_ctrl #(.FILL_W(16), .CLK_NS(TB_NS)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .tx_enabled(tx_enabled), .full_duplex(full_duplex),
		.speed_10(speed_10), .rx_fifo_used(rx_fifo_used), .rx_preamble(rx_preamble),
		.rx_da_valid(rx_da_valid), .rx_da_multicast(rx_da_multicast),
		.rx_da_broadcast(rx_da_broadcast), .rx_da_own(rx_da_own), .pause_req(pause_req),
		.pause_zero(pause_zero), .pause_ack(pause_ack), .jam(jam));
	afc_mac_model mac (.sys_clk(sys_clk), .pause_req(pause_req), .delay(ack_delay),
		.pause_ack(pause_ack));

	// Jam length in cycles, rounded up
	function automatic int exp_len(input logic [3:0] c, input logic s10);
		int t;
		t = (c < 3) ? 5000 * (c + 1) : (c == 3) ? 25000 : 50000 * (c - 3);
		t = t + (s10 ? 2200 : 0);
		return (t + TB_NS - 1) / TB_NS;
	endfunction

	task automatic stop_test;
		if (fail_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic tick;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		tick();
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		tick();
		reg_rd <= 1'b0;
		rd_val = reg_rdata;
	endtask

	// One receive event, then count jam cycles over a fixed window
	task automatic jam_len(input logic pre, input logic mc, input logic bc, input logic own);
		rx_preamble <= pre;
		rx_da_valid <= ~pre;
		rx_da_multicast <= mc;
		rx_da_broadcast <= bc;
		rx_da_own <= own;
		tick();
		rx_preamble <= 1'b0;
		rx_da_valid <= 1'b0;
		len = 0;
		repeat (260) begin
			len += (jam === 1'b1);
			tick();
		end
	endtask

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Watchdog
	initial begin
		#1000000;
		fail_count++;
		stop_test();
	end

	// Main sequence
	initial begin
		repeat (3) tick();
		reset_n <= 1'b1;
		reg_read(8'hAC);
		check(rd_val, 32'h0);
		cfg = $random(seed) & 32'hFFFFFFF0;
		reg_write(8'hAC, cfg);
		reg_read(8'hAC);
		check(rd_val, {8'h00, cfg[23:0]});
		tick();
		reg_read(8'h10);
		check(rd_val, 32'h0);
		reg_write(8'hB4, 32'hFFFFFFFF);
		reg_read(8'hAC);
		check(rd_val, {8'h00, cfg[23:0]});
		tx_enabled <= 1'b1;
		reg_write(8'hAC, 32'h0004020E);
		rx_fifo_used <= 16'd300;
		repeat (4) tick();
		check(pause_req, 1'b0);
		rx_fifo_used <= 16'd0;
		reg_write(8'hAC, 32'h00040201);
		repeat (4) tick();
		check(pause_req, 1'b0);
		rx_fifo_used <= 16'd255;
		repeat (4) tick();
		check(pause_req, 1'b0);
		rx_fifo_used <= 16'd256;
		repeat (2) tick();
		check({pause_req, pause_zero}, 2'b10);
		repeat (14) tick();
		check(pause_req, 1'b0);
		reg_read(8'hB4);
		check(rd_val, 32'h0000000C);
		rx_fifo_used <= 16'd128;
		ack_delay <= 8'h00;
		repeat (4) tick();
		check(pause_req, 1'b0);
		rx_fifo_used <= 16'd127;
		repeat (2) tick();
		check({pause_req, pause_zero}, 2'b11);
		repeat (4) tick();
		check(pause_req, 1'b0);
		full_duplex <= 1'b0;
		rx_fifo_used <= 16'd256;
		for (int i = 0; i < 6; i++) begin
			cfg = {8'h00, 16'h0402, (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed)), 4'h1};
			speed_10 <= i[0];
			reg_write(8'hAC, cfg);
			jam_len(1'b1, 1'b0, 1'b0, 1'b0);
			check(len, exp_len(cfg[7:4], i[0]));
		end
		speed_10 <= 1'b0;
		for (int k = 1; k < 4; k++) begin
			reg_write(8'hAC, 32'h00040200 | (32'h1 << k));
			for (int j = 1; j < 4; j++) begin
				jam_len(1'b0, j == 3, j == 2, j == 1);
				check(len, (k == j) ? exp_len(4'h0, 1'b0) : 0);
			end
		end
		reg_write(8'hAC, 32'h0004020F);
		jam_len(1'b0, 1'b1, 1'b1, 1'b1);
		check(len, 0);
		jam_len(1'b1, 1'b0, 1'b0, 1'b0);
		check(len, exp_len(4'h0, 1'b0));
		rx_fifo_used <= 16'd255;
		jam_len(1'b1, 1'b0, 1'b0, 1'b0);
		check(len, 0);
		rx_fifo_used <= 16'd256;
		tx_enabled <= 1'b0;
		jam_len(1'b1, 1'b0, 1'b0, 1'b0);
		check(len, 0);
		tx_enabled <= 1'b1;
		full_duplex <= 1'b1;
		ack_delay <= 8'hFF;
		repeat (2) tick();
		check({pause_req, pause_zero}, 2'b10);
		tx_enabled <= 1'b0;
		repeat (2) tick();
		check(pause_req, 1'b0);
		tx_enabled <= 1'b1;
		ack_delay <= 8'h00;
		jam_len(1'b1, 1'b0, 1'b0, 1'b0);
		check(len, 0);
		stop_test();
	end
endmodule // test_auto_flow_control
